// ---- verilog/ipe_pkg.sv ----
// constants, types and register map of the interrupt priority and enable registers
// Functional notes
// - priority bit 7 reads one, writes ignored
// - priority bit 6 raises serial port 0
// - priority bit 5 raises timer 2
// - priority bit 4 raises uart 0
// - priority bit 3 raises timer 1
// - priority bit 2 raises external interrupt 1
// - priority bit 1 raises timer 0
// - priority bit 0 raises external interrupt 0
// - mask bit 7 gates both timer 3 overflows
// - mask bit 6 gates comparator 1 edges
// - mask bit 5 gates comparator 0 edges
// - mask bit 4 gates counter array requests
// - mask bit 3 gates adc conversion done
// - mask bit 2 gates adc window compare
// - mask bit 1 gates rtc alarm
// - mask bit 0 gates smbus port requests
// - global gate off blocks every source from the high and low requests; the event irq is not gated
package ipe_pkg;

   localparam int IPE_AW = 12;
   localparam int IPE_DW = 32;
   localparam int IPE_NLEG = 7;
   localparam int IPE_NEXT = 8;
   localparam int IPE_NSRC = 15;

   // printed offsets are register indices; byte address is four times that
   localparam logic [IPE_AW-1:0] IPE_IDX_PRIO = 12'h0b8;
   localparam logic [IPE_AW-1:0] IPE_IDX_XMASK = 12'h0e6;
   localparam logic [IPE_AW-1:0] IPE_ADDR_PRIO = {IPE_IDX_PRIO[IPE_AW-3:0], 2'b00};
   localparam logic [IPE_AW-1:0] IPE_ADDR_XMASK = {IPE_IDX_XMASK[IPE_AW-3:0], 2'b00};
   localparam logic [IPE_AW-1:0] IPE_ADDR_GATE = 12'h000;
   localparam logic [IPE_AW-1:0] IPE_ADDR_STAT = 12'h004;
   localparam logic [IPE_AW-1:0] IPE_ADDR_EVMASK = 12'h008;
   localparam logic [IPE_AW-1:0] IPE_ADDR_VIEW = 12'h00c;

   localparam int IPE_BIT_UNUSED = 7;
   localparam int IPE_BIT_GATE = 7;
   localparam int IPE_BIT_T3 = 7;
   localparam int IPE_BIT_CP1 = 6;
   localparam int IPE_BIT_CP0 = 5;
   localparam int IPE_BIT_PCA = 4;
   localparam int IPE_BIT_ADC = 3;
   localparam int IPE_BIT_WIN = 2;
   localparam int IPE_BIT_RTC = 1;
   localparam int IPE_BIT_SMB = 0;
   localparam int IPE_VIEW_SVC_LO = 16;
   localparam int IPE_VIEW_LOW = 18;
   localparam int IPE_VIEW_HIGH = 19;

   localparam logic IPE_PRIO_UNUSED_RD = 1'b1;
   localparam logic [1:0] IPE_RESP_OKAY = 2'h0;
   localparam logic [1:0] IPE_RESP_SLVERR = 2'h2;
   localparam logic [IPE_DW-1:0] IPE_RDATA_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      IPE_SVC_NONE = 2'b00,
      IPE_SVC_LOW = 2'b01,
      IPE_SVC_HIGH_OVER_LOW = 2'b11,
      IPE_SVC_HIGH = 2'b10
   } ipe_svc_t;

   typedef struct packed {
      logic timer_three_low_overflow;
      logic timer_three_high_overflow;
      logic comparator_one_rise_flag;
      logic comparator_one_fall_flag;
      logic comparator_zero_rise_flag;
      logic comparator_zero_fall_flag;
      logic counter_array_req;
      logic conversion_done_flag;
      logic window_compare_flag;
      logic rtc_alarm_req;
      logic smbus_port_req;
   } ipe_ext_flags_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [IPE_DW-1:0] rdata;
      logic aw_got;
      logic w_got;
      logic [IPE_AW-1:0] waddr;
      logic [7:0] wdata;
      logic wlane;
      logic [IPE_NLEG-1:0] prio;
      logic [IPE_NEXT-1:0] xmask;
      logic gate;
      logic [IPE_NSRC-1:0] ev_mask;
      logic [IPE_NSRC-1:0] ev_stat;
      logic [IPE_NSRC-1:0] prev_req;
      ipe_svc_t svc;
      logic high_req;
      logic low_req;
      logic irq;
   } ipe_state_t;

   localparam ipe_state_t IPE_STATE_RST = '0;

endpackage

// ---- verilog/ipe_top.sv ----
// interrupt priority select, extended mask and preemption tracking behind axi4-lite
`timescale 1ns/100ps
module ipe_top
   import ipe_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [IPE_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [IPE_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [IPE_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [IPE_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [IPE_NLEG-1:0] legacy_req,
   input wire ipe_ext_flags_t ext_flags,
   input wire logic isr_enter,
   input wire logic isr_return,
   output logic irq_high_req,
   output logic irq_low_req,
   output ipe_svc_t svc_level,
   output logic irq
);

   ipe_state_t s_r;
   ipe_state_t s_nxt;
   logic [IPE_NEXT-1:0] ext_raw;
   logic [IPE_NEXT-1:0] ext_en;
   logic [IPE_NSRC-1:0] req_vec;
   logic [IPE_NSRC-1:0] ev_clr;
   logic hi_pend;
   logic lo_pend;
   logic in_high;
   logic addr_ok;

   always_comb begin
      s_nxt = s_r;
      ev_clr = '0;
      addr_ok = 1'b0;

      // extended sources folded into one request each
      ext_raw = '0;
      ext_raw[IPE_BIT_T3] = ext_flags.timer_three_low_overflow
         | ext_flags.timer_three_high_overflow;
      ext_raw[IPE_BIT_CP1] = ext_flags.comparator_one_rise_flag
         | ext_flags.comparator_one_fall_flag;
      ext_raw[IPE_BIT_CP0] = ext_flags.comparator_zero_rise_flag
         | ext_flags.comparator_zero_fall_flag;
      ext_raw[IPE_BIT_PCA] = ext_flags.counter_array_req;
      ext_raw[IPE_BIT_ADC] = ext_flags.conversion_done_flag;
      ext_raw[IPE_BIT_WIN] = ext_flags.window_compare_flag;
      ext_raw[IPE_BIT_RTC] = ext_flags.rtc_alarm_req;
      ext_raw[IPE_BIT_SMB] = ext_flags.smbus_port_req;
      ext_en = ext_raw & s_r.xmask;
      req_vec = {ext_en, legacy_req};

      // legacy sources arrive already enabled; each priority bit picks its level
      hi_pend = s_r.gate & (|(legacy_req & s_r.prio));
      lo_pend = s_r.gate & ((|(legacy_req & ~s_r.prio)) | (|ext_en));

      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata[7:0];
         s_nxt.wlane = s_axi_wstrb[0];
      end
      if (s_r.aw_got && s_r.w_got) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = IPE_RESP_OKAY;
         case (s_r.waddr)
            IPE_ADDR_PRIO: begin
               // bit 7 has no storage
               if (s_r.wlane) begin
                  s_nxt.prio = s_r.wdata[IPE_NLEG-1:0];
               end
            end
            IPE_ADDR_XMASK: begin
               if (s_r.wlane) begin
                  s_nxt.xmask = s_r.wdata;
               end
            end
            IPE_ADDR_GATE: begin
               if (s_r.wlane) begin
                  s_nxt.gate = s_r.wdata[IPE_BIT_GATE];
               end
            end
            IPE_ADDR_EVMASK: begin
               // mask spans two byte lanes; only lane 0 is written, bits above 7 never are
               if (s_r.wlane) begin
                  s_nxt.ev_mask = {s_r.ev_mask[IPE_NSRC-1:8], s_r.wdata};
               end
            end
            IPE_ADDR_STAT: begin
               // read-only, write ignored
            end
            IPE_ADDR_VIEW: begin
               // read-only, write ignored
            end
            default: begin
               s_nxt.bresp = IPE_RESP_SLVERR;
            end
         endcase
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
      s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;

      // read channel
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = IPE_RDATA_ZERO;
         addr_ok = 1'b1;
         case (s_axi_araddr)
            IPE_ADDR_PRIO: begin
               s_nxt.rdata[IPE_BIT_UNUSED] = IPE_PRIO_UNUSED_RD;
               s_nxt.rdata[IPE_NLEG-1:0] = s_r.prio;
            end
            IPE_ADDR_XMASK: begin
               s_nxt.rdata[IPE_NEXT-1:0] = s_r.xmask;
            end
            IPE_ADDR_GATE: begin
               s_nxt.rdata[IPE_BIT_GATE] = s_r.gate;
            end
            IPE_ADDR_STAT: begin
               s_nxt.rdata[IPE_NSRC-1:0] = s_r.ev_stat;
               ev_clr = '1;
            end
            IPE_ADDR_EVMASK: begin
               s_nxt.rdata[IPE_NSRC-1:0] = s_r.ev_mask;
            end
            IPE_ADDR_VIEW: begin
               s_nxt.rdata[IPE_NSRC-1:0] = req_vec;
               s_nxt.rdata[IPE_VIEW_SVC_LO+1:IPE_VIEW_SVC_LO] = s_r.svc;
               s_nxt.rdata[IPE_VIEW_LOW] = s_r.low_req;
               s_nxt.rdata[IPE_VIEW_HIGH] = s_r.high_req;
            end
            default: begin
               addr_ok = 1'b0;
            end
         endcase
         s_nxt.rresp = addr_ok ? IPE_RESP_OKAY : IPE_RESP_SLVERR;
      end
      s_nxt.arready = ~s_nxt.rvalid;

      // sticky events on a rising request; a new edge beats the read clear
      s_nxt.prev_req = req_vec;
      s_nxt.ev_stat = (s_r.ev_stat & ~ev_clr) | (req_vec & ~s_r.prev_req);
      s_nxt.irq = |(s_nxt.ev_stat & s_r.ev_mask);

      // service level tracking; core takes whichever request it sees
      case (s_r.svc)
         IPE_SVC_NONE: begin
            if (isr_enter && s_r.high_req) begin
               s_nxt.svc = IPE_SVC_HIGH;
            end else if (isr_enter && s_r.low_req) begin
               s_nxt.svc = IPE_SVC_LOW;
            end
         end
         IPE_SVC_LOW: begin
            if (isr_enter && s_r.high_req) begin
               s_nxt.svc = IPE_SVC_HIGH_OVER_LOW;
            end else if (isr_return) begin
               s_nxt.svc = IPE_SVC_NONE;
            end
         end
         IPE_SVC_HIGH_OVER_LOW: begin
            if (isr_return) begin
               s_nxt.svc = IPE_SVC_LOW;
            end
         end
         IPE_SVC_HIGH: begin
            if (isr_return) begin
               s_nxt.svc = IPE_SVC_NONE;
            end
         end
         default: begin
            s_nxt.svc = IPE_SVC_NONE;
         end
      endcase

      // nothing preempts a high handler; low waits for an idle core
      in_high = (s_nxt.svc == IPE_SVC_HIGH) || (s_nxt.svc == IPE_SVC_HIGH_OVER_LOW);
      s_nxt.high_req = hi_pend & ~in_high;
      s_nxt.low_req = lo_pend & (s_nxt.svc == IPE_SVC_NONE);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= IPE_STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rdata = s_r.rdata;
   assign irq_high_req = s_r.high_req;
   assign irq_low_req = s_r.low_req;
   assign svc_level = s_r.svc;
   assign irq = s_r.irq;

endmodule

// ---- verification/ipe_monitor.sv ----
// concurrent checks on the ports of the interrupt priority and enable block
`timescale 1ns/100ps
module ipe_monitor
   import ipe_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [IPE_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [IPE_DW-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [IPE_NLEG-1:0] legacy_req,
   input wire logic isr_enter,
   input wire logic irq_high_req,
   input wire logic irq_low_req,
   input wire ipe_svc_t svc_level
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_prio;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == IPE_ADDR_PRIO;
   endsequence
   sequence s_hi_over;
      svc_level == IPE_SVC_LOW && irq_high_req && isr_enter;
   endsequence
   a_prio_top_one: assert property (s_rd_prio |=> s_axi_rdata[IPE_BIT_UNUSED])
      else $error("priority top bit read zero");
   a_high_src: assert property (irq_high_req |-> $past(legacy_req) != '0)
      else $error("high request with no legacy source");
   a_high_no_nest: assert property (svc_level[1] |-> !irq_high_req)
      else $error("high request while high in service");
   a_low_when_idle: assert property (irq_low_req |-> svc_level == IPE_SVC_NONE)
      else $error("low request while in service");
   a_high_preempts: assert property (s_hi_over |=> svc_level == IPE_SVC_HIGH_OVER_LOW)
      else $error("high did not preempt low");
   a_low_no_preempt: assert property (svc_level == IPE_SVC_HIGH && isr_enter |=>
      svc_level == IPE_SVC_HIGH)
      else $error("high service left on enter");
   a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during answer");
endmodule
bind ipe_top ipe_monitor i_ipe_monitor (.*);

// ---- verification/ipe_partner.sv ----
// processor core and interrupt sources facing the block
`timescale 1ns/100ps
module ipe_partner
   import ipe_pkg::*;
(
   input wire logic aclk,
   output logic [IPE_NLEG-1:0] legacy_req,
   output ipe_ext_flags_t ext_flags,
   output logic isr_enter,
   output logic isr_return
);
   initial begin
      legacy_req = '0;
      ext_flags = '0;
      isr_enter = 1'h0;
      isr_return = 1'h0;
   end
   task automatic src(input logic [6:0] l, input logic [10:0] e);
      @(posedge aclk);
      legacy_req <= l;
      ext_flags <= e;
   endtask
   // lag models a core busy with other work before it vectors
   task automatic take(input int lag);
      repeat (lag + 1) @(posedge aclk);
      isr_enter <= 1'h1;
      @(posedge aclk);
      isr_enter <= 1'h0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic leave();
      @(posedge aclk);
      isr_return <= 1'h1;
      @(posedge aclk);
      isr_return <= 1'h0;
      repeat (3) @(posedge aclk);
   endtask
endmodule

// ---- verification/ipe_top_tb.sv ----
// self-checking bench for the interrupt priority and enable block
`timescale 1ns/100ps
module ipe_top_tb;
   import ipe_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [IPE_AW-1:0] awaddr = '0;
   logic [IPE_AW-1:0] araddr = '0;
   logic [IPE_DW-1:0] wdata = '0;
   logic [3:0] wstrb = 4'h1;
   logic [1:0] rresp, rd_resp;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq_high_req, irq_low_req, irq;
   logic isr_enter, isr_return;
   logic [1:0] bresp;
   logic [IPE_DW-1:0] rdata, rd_val;
   logic [IPE_NLEG-1:0] legacy_req;
   ipe_ext_flags_t ext_flags;
   ipe_svc_t svc_level;
   int n_mismatch = 0;
   int n_compared = 0;
   always #50 aclk = ~aclk;
   ipe_top i_ipe_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .legacy_req(legacy_req),
      .ext_flags(ext_flags), .isr_enter(isr_enter), .isr_return(isr_return),
      .irq_high_req(irq_high_req), .irq_low_req(irq_low_req), .svc_level(svc_level), .irq(irq));
   ipe_partner i_ipe_partner (.aclk(aclk), .legacy_req(legacy_req), .ext_flags(ext_flags),
      .isr_enter(isr_enter), .isr_return(isr_return));
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hang(input int n);
      if (n >= 40) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   // bready raised with the request, so the answer is taken on its first edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 40 && !bvalid; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      hang(n);
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 40 && !rvalid; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end
      rd_val = rdata;
      rd_resp = rresp;
      rready <= 1'h0;
      hang(n);
   endtask
   task automatic rq(input logic [1:0] e);
      repeat (3) @(posedge aclk);
      chk("high and low request", 32'(e), 32'({irq_high_req, irq_low_req}));
   endtask
   task automatic t_regs();
      rd(IPE_ADDR_PRIO);
      chk("priority reset", 32'h0000_0080, rd_val);
      rd(IPE_ADDR_XMASK);
      chk("mask reset", 32'h0000_0000, rd_val);
      wr(IPE_ADDR_PRIO, 8'h55);
      chk("mapped write", 32'(IPE_RESP_OKAY), 32'(bresp));
      rd(IPE_ADDR_PRIO);
      chk("priority readback", 32'h0000_00d5, rd_val);
      // lane 0 off: the write must leave the register alone
      wstrb <= 4'h0;
      wr(IPE_ADDR_PRIO, 8'h2a);
      wstrb <= 4'h1;
      rd(IPE_ADDR_PRIO);
      chk("priority lane off", 32'h0000_00d5, rd_val);
      wr(12'h0f0, 8'hff);
      chk("unmapped write", 32'(IPE_RESP_SLVERR), 32'(bresp));
      rd(12'h0f0);
      chk("unmapped read", 32'(IPE_RESP_SLVERR), 32'(rd_resp));
      chk("unmapped data", 32'h0000_0000, rd_val);
   endtask
   task automatic t_prio();
      wr(IPE_ADDR_GATE, 8'h80);
      for (int i = 0; i < 7; i++) begin
         wr(IPE_ADDR_PRIO, 8'(1 << i));
         i_ipe_partner.src(7'(1 << i), 11'h000);
         rq(2'h2);
         i_ipe_partner.src(7'(1 << ((i + 1) % 7)), 11'h000);
         rq(2'h1);
      end
   endtask
   task automatic t_ext();
      logic [10:0] f;
      wr(IPE_ADDR_PRIO, 8'h00);
      for (int i = 0; i < 8; i++) begin
         f = i == 7 ? 11'h200 : i == 6 ? 11'h100 : i == 5 ? 11'h020 : 11'(1 << i);
         wr(IPE_ADDR_XMASK, 8'(1 << i));
         i_ipe_partner.src(7'h00, f);
         rq(2'h1);
         wr(IPE_ADDR_XMASK, ~8'(1 << i));
         rq(2'h0);
      end
      // the other flag of each paired source
      wr(IPE_ADDR_XMASK, 8'he0);
      i_ipe_partner.src(7'h00, 11'h400);
      rq(2'h1);
      i_ipe_partner.src(7'h00, 11'h080);
      rq(2'h1);
      i_ipe_partner.src(7'h00, 11'h040);
      rq(2'h1);
   endtask
   task automatic t_gate();
      wr(IPE_ADDR_XMASK, 8'hff);
      wr(IPE_ADDR_PRIO, 8'h01);
      i_ipe_partner.src(7'h03, 11'h7ff);
      rq(2'h3);
      wr(IPE_ADDR_GATE, 8'h00);
      rq(2'h0);
      wr(IPE_ADDR_GATE, 8'h80);
   endtask
   task automatic t_svc();
      i_ipe_partner.src(7'h02, 11'h000);
      i_ipe_partner.take(0);
      chk("service", 32'(IPE_SVC_LOW), 32'(svc_level));
      i_ipe_partner.src(7'h03, 11'h000);
      rq(2'h2);
      i_ipe_partner.take(3);
      chk("service", 32'(IPE_SVC_HIGH_OVER_LOW), 32'(svc_level));
      i_ipe_partner.leave();
      i_ipe_partner.leave();
      i_ipe_partner.take(0);
      i_ipe_partner.take(1);
      chk("service", 32'(IPE_SVC_HIGH), 32'(svc_level));
      rd(IPE_ADDR_VIEW);
      chk("view", 32'h0002_0003, rd_val);
      i_ipe_partner.leave();
   endtask
   task automatic t_irq();
      wr(IPE_ADDR_EVMASK, 8'h01);
      rd(IPE_ADDR_EVMASK);
      chk("event mask", 32'h0000_0001, rd_val);
      i_ipe_partner.src(7'h00, 11'h000);
      rd(IPE_ADDR_STAT);
      i_ipe_partner.src(7'h01, 11'h000);
      rq(2'h2);
      chk("irq set", 32'h0000_0001, 32'(irq));
      rd(IPE_ADDR_STAT);
      chk("status", 32'h0000_0001, rd_val);
      rq(2'h2);
      chk("irq cleared", 32'h0000_0000, 32'(irq));
   endtask
   // second reset in mid-run; sources stay active across it
   task automatic t_rst();
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(IPE_ADDR_PRIO);
      chk("priority after reset", 32'h0000_0080, rd_val);
      rd(IPE_ADDR_GATE);
      chk("gate after reset", 32'h0000_0000, rd_val);
      chk("request after reset", 32'h0000_0000, 32'({irq_high_req, irq_low_req}));
      chk("service after reset", 32'(IPE_SVC_NONE), 32'(svc_level));
      chk("irq after reset", 32'h0000_0000, 32'(irq));
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_prio();
      t_ext();
      t_gate();
      t_svc();
      t_irq();
      t_rst();
      give_verdict();
   end
endmodule
